//--- bench/cis_host_model.sv
// Purpose: host controller driving the serial control port
// Assumes: 800 ns serial clock, 24-bit frames, msb first
// Notes:   serial clock stands low between frames
module cis_host_model (
  input  wire logic clk_sys,
  input  wire logic spiDataOut,
  output logic      spiClk,
  output logic      spiCsN,
  output logic      spiDataIn
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    spiClk    = 1'b0;
    spiCsN    = 1'b1;
    spiDataIn = 1'b0;
  end
  // one access per frame, select released between frames
  task automatic xfer(input logic rw, input logic [14:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    logic [23:0] f;
    f = {rw, a, d};
    q = 8'h00;
    @(posedge clk_sys);
    spiCsN <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      spiDataIn <= f[i];
      repeat (4) @(posedge clk_sys);
      spiClk <= 1'b1;
      repeat (2) @(posedge clk_sys);
      // sampled mid high phase, well clear of the resync delay
      @(negedge clk_sys);
      if (i < 8) q[i] = spiDataOut;
      repeat (2) @(posedge clk_sys);
      spiClk <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
    spiCsN    <= 1'b1;
    spiDataIn <= ~spiDataIn; // released line shows no held value
    repeat (8) @(posedge clk_sys);
  endtask : xfer
endmodule : cis_host_model

//--- bench/cis_sync_seq_assertions.sv
// Purpose: port-level checks on the start-up and resync sequencer
// Assumes: single clk_sys domain, resetn async active low
// Notes:   calCnt counts cycles since the restart pulse dropped
module cis_sync_seq_assertions #(
  parameter int CLEAN_LOCK_CYCLES = cis_pkg::CLEAN_LOCK_CYC
) (
  input wire logic                    clk_sys,
  input wire logic                    resetn,
  input wire logic                    spiClk,
  input wire logic                    spiCsN,
  input wire logic                    spiDataIn,
  input wire logic                    spiDataOut,
  input wire logic                    spiDataOutEn,
  input wire logic [cis_pkg::NCH-1:0] sysrefOut,
  input wire logic                    divReset,
  input wire logic                    synthLocked,
  input wire logic                    cleanLocked,
  input wire logic                    outputsPhased
);
  timeunit 1ns;
  timeprecision 1ns;
  int calCnt;
  // saturates so a long run never wraps back into the lock window
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) calCnt <= 0;
    else if (divReset) calCnt <= 0;
    else if (calCnt < 1000000) calCnt <= calCnt + 1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_restart_clears:
    assert property ($rose(divReset) |=> !synthLocked && !cleanLocked && !outputsPhased)
    else $error("flags not cleared by restart");
  a_restart_hold:
    assert property ($rose(divReset) |=> divReset [*8])
    else $error("restart pulse too short");
  a_synth_time:
    assert property ($rose(synthLocked) |-> calCnt >= 497 && calCnt <= 503)
    else $error("synthesis lock at wrong time");
  a_clean_time:
    assert property ($rose(cleanLocked) |->
      calCnt >= CLEAN_LOCK_CYCLES - 3 && calCnt <= CLEAN_LOCK_CYCLES + 3)
    else $error("cleanup lock at wrong time");
  a_lock_stands:
    assert property (synthLocked && !divReset |=> synthLocked || divReset)
    else $error("synthesis lock dropped without restart");
  a_phase_locked:
    assert property ($rose(outputsPhased) |-> synthLocked)
    else $error("phase flag set without lock");
  a_phase_return:
    assert property ($fell(outputsPhased) && !divReset |-> ##[1:1000] outputsPhased)
    else $error("phase flag did not return");
  a_oe_idle:
    assert property (spiCsN [*6] |-> !spiDataOutEn)
    else $error("read driver on outside frame");
  c_lock: cover property ($rose(synthLocked));
  c_phase: cover property ($rose(outputsPhased));
  c_pulse: cover property ($rose(sysrefOut[2]));
  c_read: cover property ($rose(spiDataOutEn));
endmodule : cis_sync_seq_assertions

bind cis_sync_seq cis_sync_seq_assertions #(.CLEAN_LOCK_CYCLES(CLEAN_LOCK_CYCLES)) u_chk (
  .clk_sys, .resetn, .spiClk, .spiCsN, .spiDataIn, .spiDataOut, .spiDataOutEn,
  .sysrefOut, .divReset, .synthLocked, .cleanLocked, .outputsPhased);

//--- bench/tb.sv
// Purpose: sequence-level test of start-up, reseed and pulse requests
// Assumes: timer period of 4 clocks, cleanup lock shortened to 200
// Notes:   channel 0 synced, 1 free running, 2 synced pulse mode
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PER = 4;
  logic                    clk_sys, resetn, spiClk, spiCsN, spiDataIn;
  logic                    spiDataOut, spiDataOutEn, divReset;
  logic                    synthLocked, cleanLocked, outputsPhased;
  logic [cis_pkg::NCH-1:0] sysrefOut;
  logic [7:0]              q;
  logic [14:0]             upd [5];
  logic [14:0]             hiRegs [3];
  int                      n_errors, samples_checked, hi, rises, n, oeCnt;
  always #50 clk_sys = ~clk_sys;
  // read-driver cycles, so each frame can be checked for when the pin is driven
  always @(negedge clk_sys) begin
    if (spiDataOutEn === 1'b1) oeCnt++;
  end
  cis_sync_seq #(.CLEAN_LOCK_CYCLES(200)) dut (.clk_sys, .resetn, .spiClk, .spiCsN,
    .spiDataIn, .spiDataOut, .spiDataOutEn, .sysrefOut, .divReset, .synthLocked,
    .cleanLocked, .outputsPhased);
  cis_host_model host (.clk_sys, .spiDataOut, .spiClk, .spiCsN, .spiDataIn);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] unused;
    host.xfer(1'b0, a, d, unused);
  endtask : wr
  task automatic rd(input logic [14:0] a, output logic [7:0] d);
    host.xfer(1'b1, a, 8'h00, d);
  endtask : rd
  // high cycles and rising edges of one channel over a span
  task automatic watch(input int ch, input int cyc);
    logic prev;
    prev = 1'b0;
    hi = 0;
    rises = 0;
    repeat (cyc) begin
      @(negedge clk_sys);
      if (sysrefOut[ch] === 1'b1) hi++;
      if (sysrefOut[ch] === 1'b1 && prev !== 1'b1) rises++;
      prev = sysrefOut[ch];
    end
  endtask : watch
  // reseed hold: length, synced channel quiet, free channel running
  task automatic measure();
    logic prev;
    n = 0;
    while ((outputsPhased !== 1'b0 || synthLocked !== 1'b1) && n < 1000) begin
      @(negedge clk_sys);
      n++;
    end
    repeat (2) @(negedge clk_sys);
    n = 2;
    hi = 0;
    rises = 0;
    prev = sysrefOut[1];
    while (outputsPhased !== 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
      if (sysrefOut[0] !== 1'b0) hi++;
      if (sysrefOut[1] === 1'b1 && prev === 1'b0) rises++;
      prev = sysrefOut[1];
    end
    chk(8'(n >= 6 * PER - 2 && n <= 6 * PER + 4), 8'h01);
    chk(8'(hi), 8'h00);
    chk(8'(rises > 0), 8'h01);
    watch(2, 40);
    chk(8'(rises), 8'h02);
    chk(8'(hi >= 2 * PER - 1 && hi <= 2 * PER), 8'h01);
  endtask : measure
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  initial begin
    #2_000_000;
    n_errors++;
    conclude();
  end
  initial begin
    clk_sys = 1'b0;
    resetn = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    upd = '{cis_pkg::ADDR_UPD_A, cis_pkg::ADDR_UPD_B, cis_pkg::ADDR_UPD_C,
            cis_pkg::ADDR_UPD_D, cis_pkg::ADDR_UPD_E};
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk({5'h00, outputsPhased, cleanLocked, synthLocked}, 8'h00);
    n = oeCnt;
    rd(cis_pkg::ADDR_PER_LO, q);
    chk(q, cis_pkg::PER_RESET[7:0]);
    chk(8'(oeCnt - n >= 64 && oeCnt - n <= 80), 8'h01);
    rd(cis_pkg::ADDR_PNUM, q);
    chk(q, cis_pkg::PNUM_RESET);
    foreach (upd[i]) wr(upd[i], 8'ha0 + 8'(i));
    foreach (upd[i]) begin
      rd(upd[i], q);
      chk(q, 8'ha0 + 8'(i));
    end
    rd(15'h0100, q);
    chk(q, 8'h00);
    // upper channel masks hold only the channels that exist
    hiRegs = '{cis_pkg::ADDR_CHEN_HI, cis_pkg::ADDR_SYEN_HI, cis_pkg::ADDR_PMODE_HI};
    foreach (hiRegs[i]) begin
      wr(hiRegs[i], 8'hff);
      rd(hiRegs[i], q);
      chk(q, 8'((1 << (cis_pkg::NCH - 8)) - 1));
      wr(hiRegs[i], 8'h00);
    end
    n = oeCnt;
    wr(cis_pkg::ADDR_PER_LO, 8'h04);
    chk(8'(oeCnt - n), 8'h00);
    wr(cis_pkg::ADDR_PER_HI, 8'h00);
    wr(cis_pkg::ADDR_CHEN_LO, 8'h07);
    wr(cis_pkg::ADDR_SYEN_LO, 8'h05);
    wr(cis_pkg::ADDR_PMODE_LO, 8'h04);
    wr(cis_pkg::ADDR_PNUM, 8'h02);
    // loop dividers and terminations live in the analog section; only spacing is kept
    repeat (2) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    repeat (100) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    wr(cis_pkg::ADDR_CTRL, 8'h01);
    chk({7'h00, divReset}, 8'h01);
    wr(cis_pkg::ADDR_CTRL, 8'h00);
    // early reseed must wait for lock
    wr(cis_pkg::ADDR_CTRL, 8'h02);
    rd(cis_pkg::ADDR_STATUS, q);
    chk({7'h00, q[3]}, 8'h01);
    chk({7'h00, q[0]}, 8'h00);
    measure();
    chk({7'h00, synthLocked}, 8'h01);
    chk({7'h00, outputsPhased}, 8'h01);
    fork
      wr(cis_pkg::ADDR_CTRL, 8'h02);
      measure();
    join
    repeat (20 * PER) @(posedge clk_sys);
    fork
      wr(cis_pkg::ADDR_CTRL, 8'h04);
      watch(2, 300);
    join
    chk(8'(rises), 8'h02);
    chk({7'h00, cleanLocked}, 8'h01);
    wr(cis_pkg::ADDR_CHEN_LO, 8'h00);
    repeat (10) @(negedge clk_sys);
    chk({7'h00, |sysrefOut}, 8'h00);
    conclude();
  end
endmodule : tb

//--- verilog/cis_pkg.sv
// Purpose: constants for the clock start-up and resync sequencer
// Assumes: 10 MHz system clock, serial port frames of 24 bits
// Notes:   offsets are byte addresses on the serial port
package cis_pkg;
  localparam int          CLK_MHZ         = 10;
  localparam int          NCH             = 14;
  // serial frame: 1 direction bit, 15 address bits, 8 data bits
  localparam int          FRAME_BITS      = 24;
  localparam int          HDR_BITS        = 16;
  localparam int          ADDR_BITS       = 15;
  localparam logic [4:0]  FRAME_LAST      = 5'h17;
  localparam logic [4:0]  HDR_LAST        = 5'h0f;
  // update registers loaded after reset release
  localparam logic [14:0] ADDR_UPD_A      = 15'h009f;
  localparam logic [14:0] ADDR_UPD_B      = 15'h00a0;
  localparam logic [14:0] ADDR_UPD_C      = 15'h00a5;
  localparam logic [14:0] ADDR_UPD_D      = 15'h00a8;
  localparam logic [14:0] ADDR_UPD_E      = 15'h00b0;
  // control and status
  localparam logic [14:0] ADDR_CTRL       = 15'h0001;
  localparam logic [14:0] ADDR_STATUS     = 15'h0002;
  localparam logic [14:0] ADDR_PER_LO     = 15'h0003;
  localparam logic [14:0] ADDR_PER_HI     = 15'h0004;
  localparam logic [14:0] ADDR_CHEN_LO    = 15'h0005;
  localparam logic [14:0] ADDR_CHEN_HI    = 15'h0006;
  localparam logic [14:0] ADDR_SYEN_LO    = 15'h0007;
  localparam logic [14:0] ADDR_SYEN_HI    = 15'h0008;
  localparam logic [14:0] ADDR_PMODE_LO   = 15'h0009;
  localparam logic [14:0] ADDR_PMODE_HI   = 15'h000a;
  localparam logic [14:0] ADDR_PNUM       = 15'h000b;
  localparam int          CTRL_RESTART    = 0;
  localparam int          CTRL_RESEED     = 1;
  localparam int          CTRL_PULSE      = 2;
  localparam int          ST_SYNTH_LOCK   = 0;
  localparam int          ST_CLEAN_LOCK   = 1;
  localparam int          ST_PHASED       = 2;
  localparam int          ST_RESEED_PEND  = 3;
  localparam int          ST_PULSE_PEND   = 4;
  localparam logic [11:0] PER_RESET       = 12'h001;
  localparam logic [7:0]  PNUM_RESET      = 8'h01;
  // lock and settle times
  localparam int          SYNTH_LOCK_US   = 50;
  localparam int          SYNTH_LOCK_CYC  = SYNTH_LOCK_US * CLK_MHZ;
  localparam int          CLEAN_LOCK_MS   = 50;
  localparam int          CLEAN_LOCK_CYC  = CLEAN_LOCK_MS * 1000 * CLK_MHZ;
  localparam logic [4:0]  SYNC_PERIODS    = 5'h06;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_RESET = 5'b00010,
    ST_CAL   = 5'b00100,
    ST_RUN   = 5'b01000,
    ST_SYNC  = 5'b10000
  } cis_state_type;
endpackage : cis_pkg

//--- verilog/cis_sync_seq.sv
// Purpose: start-up, restart, reseed and pulse sequencing of the clock generator
// Assumes: host drives the serial port; spiClk is slow against clk_sys
// Notes:   loop lock is modelled by fixed settle counts
// Summary of operation
// - restart bit one then zero resets dividers and begins calibration.
// - cleanup loop locks in parallel; synthesis loop locks after fifty microseconds.
// - reseed request aligns divider phases and emits initial pulse stream.
// - phase status flag goes to one once every output is phased.
// - pulse request emits pulse chain on pulse-mode sysref channels.
// - channels with sync enable cleared ignore sync and keep running.
// - channels may run continuously, switch dynamically, or burst temporarily.
// - timer counts periods from twelve-bit host count; sequences dividers.
module cis_sync_seq #(
  parameter int CLEAN_LOCK_CYCLES = cis_pkg::CLEAN_LOCK_CYC
) (
  input  wire logic                   clk_sys,
  input  wire logic                   resetn,
  input  wire logic                   spiClk,
  input  wire logic                   spiCsN,
  input  wire logic                   spiDataIn,
  output logic                        spiDataOut,
  output logic                        spiDataOutEn,
  output logic [cis_pkg::NCH-1:0]     sysrefOut,
  output logic                        divReset,
  output logic                        synthLocked,
  output logic                        cleanLocked,
  output logic                        outputsPhased
);
  localparam int NCH = cis_pkg::NCH;
  typedef struct packed {
    logic                  sclkMeta;
    logic                  sclkSync;
    logic                  sclkPrev;
    logic                  csnMeta;
    logic                  csnSync;
    logic                  sdiMeta;
    logic                  sdiSync;
    logic [4:0]            bitCnt;
    logic [22:0]           shiftIn;
    logic [7:0]            shiftOut;
    logic                  reading;
    logic                  sdo;
    logic [4:0][7:0]       upd;
    logic                  restartBit;
    logic                  reseedPend;
    logic                  pulsePend;
    logic [11:0]           sysPer;
    logic [NCH-1:0]        chanEn;
    logic [NCH-1:0]        syncEn;
    logic [NCH-1:0]        pulseMode;
    logic [7:0]            pulseNum;
    cis_pkg::cis_state_type state;
    logic [15:0]           lockCnt;
    logic [31:0]           cleanCnt;
    logic [11:0]           timerCnt;
    logic [4:0]            periodCnt;
    logic [NCH-1:0]        phase;
    logic [8:0]            pulseLeft;
    logic                  synthLock;
    logic                  cleanLock;
    logic                  phaseOk;
  } cis_regs_type;

  cis_regs_type r;
  cis_regs_type next_r;
  function automatic logic [7:0] readReg(input cis_regs_type s, input logic [14:0] a);
    logic [15:0] en;
    logic [15:0] sy;
    logic [15:0] pm;
    en = 16'(s.chanEn);
    sy = 16'(s.syncEn);
    pm = 16'(s.pulseMode);
    case (a)
      cis_pkg::ADDR_UPD_A:    readReg = s.upd[0];
      cis_pkg::ADDR_UPD_B:    readReg = s.upd[1];
      cis_pkg::ADDR_UPD_C:    readReg = s.upd[2];
      cis_pkg::ADDR_UPD_D:    readReg = s.upd[3];
      cis_pkg::ADDR_UPD_E:    readReg = s.upd[4];
      cis_pkg::ADDR_CTRL:     readReg = {7'h00, s.restartBit};
      cis_pkg::ADDR_STATUS:   readReg = {3'h0, s.pulsePend, s.reseedPend, s.phaseOk,
                                         s.cleanLock, s.synthLock};
      cis_pkg::ADDR_PER_LO:   readReg = s.sysPer[7:0];
      cis_pkg::ADDR_PER_HI:   readReg = {4'h0, s.sysPer[11:8]};
      cis_pkg::ADDR_CHEN_LO:  readReg = en[7:0];
      cis_pkg::ADDR_CHEN_HI:  readReg = en[15:8];
      cis_pkg::ADDR_SYEN_LO:  readReg = sy[7:0];
      cis_pkg::ADDR_SYEN_HI:  readReg = sy[15:8];
      cis_pkg::ADDR_PMODE_LO: readReg = pm[7:0];
      cis_pkg::ADDR_PMODE_HI: readReg = pm[15:8];
      cis_pkg::ADDR_PNUM:     readReg = s.pulseNum;
      default:                readReg = 8'h00;
    endcase
  endfunction : readReg
  always_comb begin
    logic        sclkRise;
    logic        sclkFall;
    logic        tick;
    logic        wrStrobe;
    logic [14:0] wrAddr;
    logic [7:0]  wrData;
    logic [15:0] en;
    logic [15:0] sy;
    logic [15:0] pm;
    logic [22:0] shifted;
    next_r   = r;
    sclkRise = 1'b0;
    sclkFall = 1'b0;
    tick     = 1'b0;
    wrStrobe = 1'b0;
    wrAddr   = 15'h0000;
    wrData   = 8'h00;
    en       = 16'(r.chanEn);
    sy       = 16'(r.syncEn);
    pm       = 16'(r.pulseMode);
    shifted  = {r.shiftIn[21:0], r.sdiSync};
    // two-stage synchronisers; the edge finder looks only at the second stage
    next_r.sclkMeta = spiClk;
    next_r.sclkSync = r.sclkMeta;
    next_r.sclkPrev = r.sclkSync;
    next_r.csnMeta  = spiCsN;
    next_r.csnSync  = r.csnMeta;
    next_r.sdiMeta  = spiDataIn;
    next_r.sdiSync  = r.sdiMeta;
    sclkRise = r.sclkSync & ~r.sclkPrev;
    sclkFall = ~r.sclkSync & r.sclkPrev;
    // serial port: one access per frame, so set and clear of restart are distinct writes
    if (r.csnSync) begin
      next_r.bitCnt  = 5'h00;
      next_r.reading = 1'b0;
    end else if (sclkRise) begin
      next_r.shiftIn = shifted;
      next_r.bitCnt  = r.bitCnt + 5'h01;
      if (r.bitCnt == cis_pkg::HDR_LAST) begin
        next_r.reading  = shifted[15];
        next_r.shiftOut = readReg(r, shifted[14:0]);
      end
      if (r.bitCnt == cis_pkg::FRAME_LAST && !r.shiftIn[22]) begin
        wrStrobe = 1'b1;
        wrAddr   = r.shiftIn[21:7];
        wrData   = {r.shiftIn[6:0], r.sdiSync};
      end
    end else if (sclkFall && r.reading) begin
      next_r.sdo      = r.shiftOut[7];
      next_r.shiftOut = {r.shiftOut[6:0], 1'b0};
    end
    if (wrStrobe) begin
      case (wrAddr)
        cis_pkg::ADDR_UPD_A:    next_r.upd[0] = wrData;
        cis_pkg::ADDR_UPD_B:    next_r.upd[1] = wrData;
        cis_pkg::ADDR_UPD_C:    next_r.upd[2] = wrData;
        cis_pkg::ADDR_UPD_D:    next_r.upd[3] = wrData;
        cis_pkg::ADDR_UPD_E:    next_r.upd[4] = wrData;
        cis_pkg::ADDR_CTRL: begin
          next_r.restartBit = wrData[cis_pkg::CTRL_RESTART];
          if (wrData[cis_pkg::CTRL_RESEED]) next_r.reseedPend = 1'b1;
          if (wrData[cis_pkg::CTRL_PULSE]) next_r.pulsePend = 1'b1;
        end
        cis_pkg::ADDR_PER_LO:   next_r.sysPer[7:0] = wrData;
        cis_pkg::ADDR_PER_HI:   next_r.sysPer[11:8] = wrData[3:0];
        cis_pkg::ADDR_CHEN_LO:  en[7:0] = wrData;
        cis_pkg::ADDR_CHEN_HI:  en[15:8] = wrData;
        cis_pkg::ADDR_SYEN_LO:  sy[7:0] = wrData;
        cis_pkg::ADDR_SYEN_HI:  sy[15:8] = wrData;
        cis_pkg::ADDR_PMODE_LO: pm[7:0] = wrData;
        cis_pkg::ADDR_PMODE_HI: pm[15:8] = wrData;
        cis_pkg::ADDR_PNUM:     next_r.pulseNum = wrData;
        default: ;
      endcase
    end
    next_r.chanEn    = en[NCH-1:0];
    next_r.syncEn    = sy[NCH-1:0];
    next_r.pulseMode = pm[NCH-1:0];
    // timer period in system clocks; a zero count behaves as one
    if (r.state == cis_pkg::ST_IDLE || r.state == cis_pkg::ST_RESET) begin
      next_r.timerCnt = 12'h000;
    end else if (r.timerCnt + 12'h001 >= r.sysPer) begin
      next_r.timerCnt = 12'h000;
      tick = 1'b1;
    end else begin
      next_r.timerCnt = r.timerCnt + 12'h001;
    end

    // channel phase: enabled channels toggle once per timer period
    for (int i = 0; i < NCH; i++) begin
      if (!r.chanEn[i]) begin
        next_r.phase[i] = 1'b0;
      end else if (r.state == cis_pkg::ST_SYNC && r.syncEn[i]) begin
        next_r.phase[i] = 1'b0;
      end else if (tick) begin
        next_r.phase[i] = ~r.phase[i];
      end
    end

    if (tick && r.pulseLeft != 9'h000) next_r.pulseLeft = r.pulseLeft - 9'h001;

    // cleanup loop settles alongside synthesis calibration
    if (r.state == cis_pkg::ST_CAL || r.state == cis_pkg::ST_RUN ||
        r.state == cis_pkg::ST_SYNC) begin
      if (r.cleanCnt >= 32'(CLEAN_LOCK_CYCLES - 1)) next_r.cleanLock = 1'b1;
      else next_r.cleanCnt = r.cleanCnt + 32'h1;
    end

    // restart wins from every state
    if (r.restartBit) begin
      next_r.state     = cis_pkg::ST_RESET;
      next_r.synthLock = 1'b0;
      next_r.cleanLock = 1'b0;
      next_r.phaseOk   = 1'b0;
      next_r.lockCnt   = 16'h0000;
      next_r.cleanCnt  = 32'h0;
      next_r.pulseLeft = 9'h000;
      next_r.phase     = '0;
    end else begin
      case (r.state)
        cis_pkg::ST_IDLE: ;
        cis_pkg::ST_RESET: next_r.state = cis_pkg::ST_CAL;
        cis_pkg::ST_CAL: begin
          if (r.lockCnt == 16'(cis_pkg::SYNTH_LOCK_CYC - 1)) begin
            next_r.synthLock = 1'b1;
            next_r.state     = cis_pkg::ST_RUN;
          end else begin
            next_r.lockCnt = r.lockCnt + 16'h0001;
          end
        end
        cis_pkg::ST_RUN: begin
          // reseed first; a write landing now defers the clear, so a new request wins
          if (r.reseedPend && !wrStrobe) begin
            next_r.reseedPend = 1'b0;
            next_r.phaseOk    = 1'b0;
            next_r.periodCnt  = 5'h00;
            next_r.state      = cis_pkg::ST_SYNC;
          end else if (r.pulsePend && !wrStrobe) begin
            next_r.pulsePend = 1'b0;
            next_r.pulseLeft = {r.pulseNum, 1'b0};
            for (int i = 0; i < NCH; i++) begin
              if (r.pulseMode[i]) next_r.phase[i] = 1'b0;
            end
          end
        end
        cis_pkg::ST_SYNC: begin
          if (tick) begin
            if (r.periodCnt == cis_pkg::SYNC_PERIODS - 5'h01) begin
              next_r.phaseOk = 1'b1;
              next_r.state   = cis_pkg::ST_RUN;
              // initial stream for pulse channels starts with phasing
              next_r.pulseLeft = {r.pulseNum, 1'b0};
            end else begin
              next_r.periodCnt = r.periodCnt + 5'h01;
            end
          end
        end
        default: next_r.state = cis_pkg::ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r           <= '0;
      r.csnMeta   <= 1'b1;
      r.csnSync   <= 1'b1;
      r.sysPer    <= cis_pkg::PER_RESET;
      r.pulseNum  <= cis_pkg::PNUM_RESET;
      r.state     <= cis_pkg::ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // pulse-mode channels only drive during a burst; others run freely
  for (genvar i = 0; i < NCH; i++) begin : g_out
    assign sysrefOut[i] = r.pulseMode[i] ? (r.phase[i] & (r.pulseLeft != 9'h000))
                                         : r.phase[i];
  end

  assign spiDataOut    = r.sdo;
  assign spiDataOutEn  = r.reading & ~r.csnSync;
  assign divReset      = (r.state == cis_pkg::ST_RESET) | r.restartBit;
  assign synthLocked   = r.synthLock;
  assign cleanLocked   = r.cleanLock;
  assign outputsPhased = r.phaseOk;
endmodule : cis_sync_seq
